// *** logic/pcr_clock_reset.sv ***
/*
  Core clock and reset release block: power_mgmt_control and a status
  register on APB, strap loading during reset, the rate generator for the
  core clock, the derived peripheral and sdram clocks and the core reset
  hold counter. Assumes reference clock, reset pin and straps are board
  pins asynchronous to core_clk, and an APB master on core_clk.
*/
`timescale 1ns/1ps
module pcr_clock_reset (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reference_clock_in,
  input wire logic reset_pin_n,
  input wire logic [1:0] clock_ratio_straps,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic core_clock,
  output logic peripheral_clock,
  output logic sdram_clock,
  output logic core_reset_n
);

  // ==========================================================
  // Pin synchronisation
  logic [pcr_pkg::SYNC_W-1:0] pins_s; // Pins after two flops
  logic ref_s; // Reference clock level
  logic pin_rst_n_s; // Board reset pin, active low
  logic [1:0] straps_s; // Ratio straps

  // One chain per pin bit
  pcr_sync #(
    .W(pcr_pkg::SYNC_W)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin({clock_ratio_straps, reset_pin_n, reference_clock_in}),
    .sync(pins_s)
  );

  assign ref_s = pins_s[0];
  assign pin_rst_n_s = pins_s[1];
  assign straps_s = pins_s[3:2];

  // ==========================================================
  // Reference edge detection and input divider
  logic ref_d; // Previous synchronised level
  logic half_phase; // Alternates on each reference rise
  logic next_half_phase;
  logic ref_rise; // Rising reference edge
  logic pll_edge; // Edge seen by the PLL input
  logic ctl_halve; // input_divide_enable field

  // Edge and divider combinational
  always_comb begin
    ref_rise = ref_s & ~ref_d;
    next_half_phase = half_phase;
    if (ref_rise) begin
      next_half_phase = ~half_phase;
    end
    // With the divider on, only every second rise reaches the PLL
    pll_edge = ref_rise & (~ctl_halve | half_phase); // R4
  end

  // Edge history
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ref_d <= 1'b0;
      half_phase <= 1'b0;
    end else begin
      ref_d <= ref_s;
      half_phase <= next_half_phase;
    end
  end

  // ==========================================================
  // power_mgmt_control register
  logic [6:0] ctl_mult; // pll_multiplier
  logic [1:0] ctl_div; // pll_post_divider code
  logic [1:0] ctl_sdr; // sdram_clock_ratio code
  logic [6:0] next_mult;
  logic [1:0] next_div;
  logic next_halve;
  logic [1:0] next_sdr;
  logic [6:0] strap_mult; // Multiplier picked by straps
  logic wr_pmc; // Completing write to the control word
  logic in_pin_reset; // Board reset pin held low

  // Strap decode
  always_comb begin
    case (straps_s)
      2'h0: strap_mult = pcr_pkg::STRAP_MULT_0;
      2'h1: strap_mult = pcr_pkg::STRAP_MULT_1;
      2'h2: strap_mult = pcr_pkg::STRAP_MULT_2;
      default: strap_mult = pcr_pkg::STRAP_MULT_3;
    endcase
  end

  // Control next values; reset pin overrides software
  always_comb begin
    in_pin_reset = ~pin_rst_n_s;
    wr_pmc = psel & penable & pwrite & (paddr == pcr_pkg::PMC_OFFSET);
    next_mult = ctl_mult;
    next_div = ctl_div;
    next_halve = ctl_halve;
    next_sdr = ctl_sdr;
    if (in_pin_reset) begin
      // Writes are dropped here: the straps own the ratio in reset
      next_mult = strap_mult; // R3
      next_div = pcr_pkg::DIV_RESET; // R2
    end else if (wr_pmc) begin
      // Software must pick a safe ratio; nothing here checks it
      next_mult = pwdata[pcr_pkg::MULT_LSB +: pcr_pkg::MULT_W];
      next_div = pwdata[pcr_pkg::DIV_LSB +: pcr_pkg::DIV_W]; // R2
      next_halve = pwdata[pcr_pkg::HALVE_BIT]; // R4
      next_sdr = pwdata[pcr_pkg::SDR_LSB +: pcr_pkg::SDR_W]; // R6
    end
  end

  // Control register storage
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctl_mult <= pcr_pkg::STRAP_MULT_0;
      ctl_div <= pcr_pkg::DIV_RESET;
      ctl_halve <= pcr_pkg::HALVE_RESET;
      ctl_sdr <= pcr_pkg::SDR_RESET;
    end else begin
      ctl_mult <= next_mult;
      ctl_div <= next_div;
      ctl_halve <= next_halve;
      ctl_sdr <= next_sdr;
    end
  end

  // ==========================================================
  // Core clock rate generator
  pcr_tick_if tk ();
  logic core_tick; // One core clock period elapsed

  // Feed oscillator step and post-divider
  always_comb begin
    tk.ref_edge = pll_edge;
    tk.step = {ctl_mult, 1'b0}; // R1
    tk.divisor = 5'h02 << ctl_div; // R2
  end

  pcr_tick_gen u_tick_gen (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .tk(tk)
  );

  assign core_tick = tk.tick;
  assign core_clock = tk.tick;

  // ==========================================================
  // Peripheral and sdram clocks
  logic periph_q; // Peripheral clock level
  logic next_periph;
  logic [2:0] sdr_cnt; // Core ticks inside one sdram period
  logic [2:0] next_sdr_cnt;
  logic [2:0] sdr_ratio; // Ratio from the field
  logic sdr_q; // Sdram clock pulse
  logic next_sdr_q;

  // Derived clock next values
  always_comb begin
    next_periph = periph_q;
    next_sdr_cnt = sdr_cnt;
    next_sdr_q = 1'b0;
    sdr_ratio = pcr_pkg::SDR_BASE + {1'b0, ctl_sdr};
    if (core_tick) begin
      // A toggle per core period gives exactly two per period
      next_periph = ~periph_q; // R5
      if (sdr_cnt >= sdr_ratio - 3'h1) begin
        next_sdr_cnt = 3'h0; // R6
        next_sdr_q = 1'b1; // R6
      end else begin
        next_sdr_cnt = sdr_cnt + 3'h1;
      end
    end
  end

  // Derived clock registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      periph_q <= 1'b0;
      sdr_cnt <= 3'h0;
      sdr_q <= 1'b0;
    end else begin
      periph_q <= next_periph;
      sdr_cnt <= next_sdr_cnt;
      sdr_q <= next_sdr_q;
    end
  end

  assign peripheral_clock = periph_q;
  assign sdram_clock = sdr_q;

  // ==========================================================
  // Core reset release sequencer
  pcr_pkg::pcr_state_t state;
  pcr_pkg::pcr_state_t next_state;
  logic [12:0] hold_cnt; // Reference or core cycles counted
  logic [12:0] next_hold_cnt;
  logic core_rst_q; // Core reset, active low
  logic next_core_rst;

  // Sequencer next state
  always_comb begin
    next_state = state;
    next_hold_cnt = hold_cnt;
    case (state)
      pcr_pkg::ST_HOLD: begin
        next_hold_cnt = 13'h0000;
        if (pin_rst_n_s) begin
          next_state = pcr_pkg::ST_REF;
        end
      end
      pcr_pkg::ST_REF: begin
        // Counts raw reference rises, not divided ones
        if (ref_rise) begin
          next_hold_cnt = hold_cnt + 13'h0001; // R7
          if (hold_cnt == pcr_pkg::REF_HOLD_CYCLES - 13'h0001) begin
            next_hold_cnt = 13'h0000;
            next_state = pcr_pkg::ST_CORE; // R7
          end
        end
      end
      pcr_pkg::ST_CORE: begin
        if (core_tick) begin
          next_hold_cnt = hold_cnt + 13'h0001; // R7
          if (hold_cnt[1:0] == pcr_pkg::CORE_HOLD_CYCLES - 2'h1) begin
            next_state = pcr_pkg::ST_RUN; // R7
          end
        end
      end
      pcr_pkg::ST_RUN: begin
        next_hold_cnt = 13'h0000;
      end
      default: begin
        next_state = pcr_pkg::ST_HOLD;
        next_hold_cnt = 13'h0000;
      end
    endcase
    // Any low on the pin restarts the whole hold
    if (!pin_rst_n_s) begin
      next_state = pcr_pkg::ST_HOLD; // R7
    end
    next_core_rst = (next_state == pcr_pkg::ST_RUN);
  end

  // Sequencer registers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state <= pcr_pkg::ST_HOLD;
      hold_cnt <= 13'h0000;
      core_rst_q <= 1'b0;
    end else begin
      state <= next_state;
      hold_cnt <= next_hold_cnt;
      core_rst_q <= next_core_rst;
    end
  end

  assign core_reset_n = core_rst_q;

  // ==========================================================
  // APB slave: zero wait states, read data latched in setup
  logic [31:0] rd_q; // Read data register
  logic [31:0] next_rd;
  logic addr_hit; // Address maps to a register

  // Read mux and decode
  always_comb begin
    addr_hit = (paddr == pcr_pkg::PMC_OFFSET) || (paddr == pcr_pkg::STATUS_OFFSET);
    next_rd = rd_q;
    if (psel && !penable) begin
      next_rd = 32'h00000000;
      if (paddr == pcr_pkg::PMC_OFFSET) begin
        next_rd[pcr_pkg::MULT_LSB +: pcr_pkg::MULT_W] = ctl_mult;
        next_rd[pcr_pkg::DIV_LSB +: pcr_pkg::DIV_W] = ctl_div;
        next_rd[pcr_pkg::HALVE_BIT] = ctl_halve;
        next_rd[pcr_pkg::SDR_LSB +: pcr_pkg::SDR_W] = ctl_sdr;
      end else if (paddr == pcr_pkg::STATUS_OFFSET) begin
        next_rd[pcr_pkg::STAT_CORE_RST_BIT] = core_rst_q;
        next_rd[pcr_pkg::STAT_PIN_BIT] = pin_rst_n_s;
        next_rd[pcr_pkg::STAT_STATE_LSB +: 4] = state;
        next_rd[pcr_pkg::STAT_MULT_LSB +: 2] = straps_s;
      end
    end
  end

  // Read data storage
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_q <= 32'h00000000;
    end else begin
      rd_q <= next_rd;
    end
  end

  assign prdata = rd_q;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~addr_hit;

endmodule // pcr_clock_reset

// *** logic/pcr_pkg.sv ***
/*
  Constants, field layout and state encoding for the core clock and reset
  release block. Assumes a single 40 MHz core_clk domain and an APB master
  with 32-bit data; every user writes pcr_pkg::name, nothing is imported.
*/
// How it works
// R1: oscillator is 2*multiplier*input, core divides it
// R2: post-divider 2/4/8/16 from field, 2 in reset
// R3: during reset multiplier comes from ratio straps
// R4: input-divide enable halves the reference clock
// R5: peripheral clock period is two core periods
// R6: sdram period is core period times ratio
// R7: core reset held 4096 reference plus 2 core
// R8: board holds reset low four reference cycles
// R9: board keeps pll settings stable before release
// R10: board holds reset until reference clock stable
// R11: software keeps oscillator below its maximum
// R12: software keeps core period within allowed range
package pcr_pkg;

  // ==========================================================
  // Bus geometry and register map
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam logic [11:0] PMC_OFFSET = 12'h000; // power_mgmt_control
  localparam logic [11:0] STATUS_OFFSET = 12'h004; // block status

  // ==========================================================
  // power_mgmt_control field layout
  localparam int unsigned MULT_LSB = 0;
  localparam int unsigned MULT_W = 7;
  localparam int unsigned DIV_LSB = 8;
  localparam int unsigned DIV_W = 2;
  localparam int unsigned HALVE_BIT = 10; // input_divide_enable
  localparam int unsigned SDR_LSB = 12;
  localparam int unsigned SDR_W = 2;

  // Reset values of the control fields
  localparam logic [1:0] DIV_RESET = 2'h0; // Post-divider of 2
  localparam logic HALVE_RESET = 1'b0;
  localparam logic [1:0] SDR_RESET = 2'h0;
  localparam logic [2:0] SDR_BASE = 3'h2; // Field 0 means ratio 2

  // Multiplier picked by each strap code
  localparam logic [6:0] STRAP_MULT_0 = 7'h08;
  localparam logic [6:0] STRAP_MULT_1 = 7'h20;
  localparam logic [6:0] STRAP_MULT_2 = 7'h10;
  localparam logic [6:0] STRAP_MULT_3 = 7'h08;

  // ==========================================================
  // Status register layout
  localparam int unsigned STAT_CORE_RST_BIT = 0;
  localparam int unsigned STAT_PIN_BIT = 1;
  localparam int unsigned STAT_STATE_LSB = 4;
  localparam int unsigned STAT_MULT_LSB = 8;

  // ==========================================================
  // Reset release counts and generator widths
  localparam logic [12:0] REF_HOLD_CYCLES = 13'h1000;
  localparam logic [1:0] CORE_HOLD_CYCLES = 2'h2;
  localparam int unsigned CREDIT_W = 16;
  localparam int unsigned SYNC_W = 4;

  // Reset release sequencer
  typedef enum logic [3:0] {
    ST_HOLD = 4'h1,
    ST_REF = 4'h2,
    ST_CORE = 4'h4,
    ST_RUN = 4'h8
  } pcr_state_t;

endpackage

// *** logic/pcr_tick_if.sv ***
/*
  Carrier between the top block and the rate generator: divided reference
  edges and ratio in, core clock ticks out. Assumes both ends on core_clk.
*/
`timescale 1ns/1ps
interface pcr_tick_if;
  logic ref_edge; // One PLL input edge
  logic [7:0] step; // Twice the multiplier
  logic [4:0] divisor; // Post-divider value
  logic tick; // One core clock period

  modport src (output ref_edge, output step, output divisor, input tick);
  modport gen (input ref_edge, input step, input divisor, output tick);
endinterface

// *** logic/pcr_sync.sv ***
/*
  Two-flop synchroniser for pin inputs, one chain per bit.
  Assumes inputs are asynchronous to core_clk.
*/
`timescale 1ns/1ps
module pcr_sync #(
  parameter int unsigned W = 4
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] sync
);

  // ==========================================================
  // Per-bit chain; first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic meta; // First stage, read by stage two only
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          meta <= 1'b0;
          sync[i] <= 1'b0;
        end else begin
          meta <= pin[i];
          sync[i] <= meta;
        end
      end
    end
  endgenerate

endmodule // pcr_sync

// *** logic/pcr_tick_gen.sv ***
/*
  Rate model of the oscillator and post-divider: each PLL input edge adds
  twice the multiplier to a credit, each core tick spends the divisor.
  Assumes at most one tick per core_clk: core rates up to core_clk are
  exact on average, faster ones saturate at one tick per cycle.
*/
`timescale 1ns/1ps
module pcr_tick_gen (
  input wire logic core_clk,
  input wire logic rst_n,
  pcr_tick_if.gen tk
);

  logic [pcr_pkg::CREDIT_W-1:0] credit; // Oscillator edges not yet spent
  logic [pcr_pkg::CREDIT_W-1:0] next_credit;
  logic tick_q; // Registered core tick
  logic next_tick;
  logic [pcr_pkg::CREDIT_W-1:0] credit_cap; // Most credit kept

  // ==========================================================
  // Credit arithmetic
  // Clamp: a ratio faster than core_clk would otherwise bank credit that
  // plays out as a long burst after software picks a slower ratio
  always_comb begin
    credit_cap = {8'h00, tk.step} + {11'h000, tk.divisor};
    next_tick = (credit >= {11'h000, tk.divisor}); // R1
    next_credit = credit;
    if (tk.ref_edge) begin
      next_credit = next_credit + {8'h00, tk.step}; // R1
    end
    if (next_tick) begin
      next_credit = next_credit - {11'h000, tk.divisor}; // R1
    end
    // Never reached while the core rate stays at or below core_clk
    if (next_credit > credit_cap) begin
      next_credit = credit_cap; // R1
    end
  end

  // Register credit and tick
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      credit <= '0;
      tick_q <= 1'b0;
    end else begin
      credit <= next_credit;
      tick_q <= next_tick;
    end
  end

  assign tk.tick = tick_q;

endmodule // pcr_tick_gen

// *** verif/pcr_board_model.sv ***
/*
  Board model: free-running reference oscillator, reset pin and ratio
  straps. Assumes the bench asks for a reset through req_n.
*/
`timescale 1ns/1ps
module pcr_board_model (
  input wire logic req_n,
  input wire logic [1:0] strap_req,
  output logic reference_clock_in,
  output logic reset_pin_n,
  output logic [1:0] clock_ratio_straps
);
  // ==========
  // Reference at 10 MHz, odd phase against core_clk
  initial begin
    reference_clock_in = 1'b0;
    #13;
    forever #50 reference_clock_in = ~reference_clock_in;
  end

  // Reference cycles spent low since the pin fell or the straps last moved
  logic [5:0] low_cnt;
  // Reference cycles since the oscillator started; 100 is ten microseconds
  logic [6:0] run_cnt;

  // ==========
  // Reset pin; straps only move while it is low; one process drives all
  initial begin
    reset_pin_n = 1'b0;
    clock_ratio_straps = 2'h0;
    low_cnt = 6'h00;
    run_cnt = 7'h00;
    forever begin
      @(posedge reference_clock_in);
      run_cnt <= (run_cnt == 7'h64) ? run_cnt : run_cnt + 7'h01;
      if (!reset_pin_n && strap_req != clock_ratio_straps) begin
        clock_ratio_straps <= strap_req;
        low_cnt <= 6'h00;
      end else if (!reset_pin_n) begin
        low_cnt <= (low_cnt == 6'h3F) ? low_cnt : low_cnt + 6'h01;
        // Twenty settled cycles also covers the four-cycle low minimum
        reset_pin_n <= req_n && low_cnt >= 6'h14 && run_cnt == 7'h64;
      end else if (!req_n) begin
        reset_pin_n <= 1'b0;
        low_cnt <= 6'h00;
      end
    end
  end
endmodule // pcr_board_model

// *** verif/pcr_clock_reset_sva.sv ***
/*
  Checker for the clock and reset block; sees only its ports.
  Assumes the reference clock runs below half of core_clk.
*/
`timescale 1ns/1ps
module pcr_clock_reset_sva (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reference_clock_in,
  input wire logic reset_pin_n,
  input wire logic [1:0] clock_ratio_straps,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic core_clock,
  input wire logic peripheral_clock,
  input wire logic sdram_clock,
  input wire logic core_reset_n
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ==========
  // Raw reference rises since both resets let go; saturates
  logic ref_q;
  logic [12:0] ref_cnt;
  always_ff @(posedge core_clk) begin
    ref_q <= reference_clock_in;
    if (!rst_n || !reset_pin_n) begin
      ref_cnt <= 13'h0000;
    end else if (reference_clock_in && !ref_q && ref_cnt != 13'h1FFF) begin
      ref_cnt <= ref_cnt + 13'h0001;
    end
  end

  // ==========
  // Bus answers
  a_apb_ready: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  a_apb_unmapped: assert property (psel && penable && paddr != 12'h000
    && paddr != 12'h004 |-> pslverr) else $error("unmapped not refused");
  a_apb_mapped: assert property (psel && penable && (paddr == 12'h000
    || paddr == 12'h004) |-> !pslverr) else $error("mapped refused");

  // ==========
  // Core reset hold and release; sync lag allows a few cycles
  a_reset_quiet: assert property ($rose(rst_n) |-> !core_reset_n
    && !core_clock && !sdram_clock) else $error("outputs live in reset");
  a_core_hold: assert property (!reset_pin_n [*5] |-> !core_reset_n)
    else $error("core reset not held");
  a_release_count: assert property ($rose(core_reset_n) |->
    ref_cnt >= 13'h1000 && ref_cnt <= 13'h1002) else $error("release count");

  // ==========
  // Derived clocks follow core pulses
  a_periph_cause: assert property ($changed(peripheral_clock) |->
    core_clock || $past(core_clock)) else $error("periph moved alone");
  a_periph_follow: assert property (core_clock |->
    ##[0:1] $changed(peripheral_clock)) else $error("periph missed pulse");
  a_sdram_cause: assert property (sdram_clock |->
    core_clock || $past(core_clock)) else $error("sdram pulse alone");

  c_release: cover property ($rose(core_reset_n));
  c_sdram: cover property (sdram_clock);
  c_refused: cover property (psel && penable && pslverr);
endmodule // pcr_clock_reset_sva

bind pcr_clock_reset pcr_clock_reset_sva pcr_clock_reset_sva_inst (
  .core_clk(core_clk), .rst_n(rst_n), .reference_clock_in(reference_clock_in),
  .reset_pin_n(reset_pin_n), .clock_ratio_straps(clock_ratio_straps),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .core_clock(core_clock), .peripheral_clock(peripheral_clock),
  .sdram_clock(sdram_clock), .core_reset_n(core_reset_n));

// *** verif/pcr_clock_reset_tb.sv ***
/*
  Bench for the clock and reset block: APB tasks, board model, rate counts.
  Assumes the design answers APB whenever pready is high.
*/
`timescale 1ns/1ps
module pcr_clock_reset_tb;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_n = 1'b0;
  logic [1:0] strap_req = 2'h0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, wv;
  logic pready, pslverr, core_clock, peripheral_clock, sdram_clock;
  logic core_reset_n, reference_clock_in, reset_pin_n, er;
  logic [1:0] clock_ratio_straps;
  logic win = 1'b0;
  logic ref_q = 1'b0;
  logic per_q = 1'b0;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int n_ref, n_core, n_per, n_sd, ex;
  // Rate cases: multiplier, divider code, input halving
  int mt[4] = '{3, 8, 16, 5};
  int dv[4] = '{0, 2, 3, 1};
  int iv[4] = '{0, 0, 1, 1};

  always #12.5 core_clk = ~core_clk;

  pcr_board_model pcr_board_model_inst (.req_n(req_n), .strap_req(strap_req),
    .reference_clock_in(reference_clock_in), .reset_pin_n(reset_pin_n),
    .clock_ratio_straps(clock_ratio_straps));
  pcr_clock_reset pcr_clock_reset_inst (.core_clk(core_clk), .rst_n(rst_n),
    .reference_clock_in(reference_clock_in), .reset_pin_n(reset_pin_n),
    .clock_ratio_straps(clock_ratio_straps), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .core_clock(core_clock),
    .peripheral_clock(peripheral_clock), .sdram_clock(sdram_clock),
    .core_reset_n(core_reset_n));

  // ==========
  // Shared helpers
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d, checks %0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Counts carry burst jitter, so compare within a tolerance
  function automatic logic near(input int a, input int b, input int t);
    return (a - b <= t) && (b - a <= t);
  endfunction

  function automatic logic [6:0] smult(input int s);
    case (s)
      0: smult = pcr_pkg::STRAP_MULT_0;
      1: smult = pcr_pkg::STRAP_MULT_1;
      2: smult = pcr_pkg::STRAP_MULT_2;
      default: smult = pcr_pkg::STRAP_MULT_3;
    endcase
  endfunction

  // One APB transfer; rd and er taken at the pready edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) @(posedge core_clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Release the board reset and time the core release in core_clk cycles
  task automatic release_core();
    int n;
    n = 0;
    req_n <= 1'b1;
    while (reset_pin_n !== 1'b1) @(posedge core_clk);
    while (core_reset_n !== 1'b1) begin
      @(posedge core_clk);
      n++;
    end
    check({31'h0, near(n, 16390, 10)}, 32'h1);
    apb(1'b0, pcr_pkg::STATUS_OFFSET, 32'h0);
    check(rd & 32'h0F3, 32'h083);
  endtask

  // ==========
  // Window counters and the hang limit (about 35k cycles expected)
  always @(posedge core_clk) begin
    cyc++;
    ref_q <= reference_clock_in;
    per_q <= peripheral_clock;
    if (win) begin
      n_core += (core_clock === 1'b1);
      n_sd += (sdram_clock === 1'b1);
      n_per += (peripheral_clock !== per_q);
      n_ref += (reference_clock_in && !ref_q);
    end
    if (cyc == 60000) begin
      num_errors++;
      end_of_test();
    end
  end

  // ==========
  // Main sequence
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    // Every strap code while the board holds reset
    for (int s = 0; s < 4; s++) begin
      strap_req <= 2'(s);
      repeat (60) @(posedge core_clk);
      apb(1'b0, pcr_pkg::PMC_OFFSET, 32'h0);
      check(rd & 32'h7F, {25'h0, smult(s)});
      apb(1'b0, pcr_pkg::STATUS_OFFSET, 32'h0);
      check(rd & 32'h301, {22'h0, 2'(s), 8'h00});
    end
    // Writes during reset are dropped, divider stays at 2
    apb(1'b1, pcr_pkg::PMC_OFFSET, 32'h0000_0304);
    apb(1'b0, pcr_pkg::PMC_OFFSET, 32'h0);
    check(rd, {25'h0, pcr_pkg::STRAP_MULT_3});
    release_core();
    // Rates for every divider and sdram code, input halving both ways
    for (int k = 0; k < 4; k++) begin
      wv = 32'(mt[k] | (dv[k] << 8) | (iv[k] << 10) | (k << 12));
      apb(1'b1, pcr_pkg::PMC_OFFSET, wv);
      apb(1'b0, pcr_pkg::PMC_OFFSET, 32'h0);
      check(rd, wv);
      repeat (40) @(posedge core_clk);
      n_ref = 0;
      n_core = 0;
      n_per = 0;
      n_sd = 0;
      win = 1'b1;
      while (n_ref < 64) @(posedge core_clk);
      win = 1'b0;
      ex = 128 * mt[k] / ((2 << dv[k]) * (1 + iv[k]));
      check({31'h0, near(n_core, ex, 2)}, 32'h1);
      check({31'h0, near(n_per, n_core, 1)}, 32'h1);
      check({31'h0, near(n_sd, n_core / (k + 2), 1)}, 32'h1);
    end
    // Unmapped place is refused and reads zero
    apb(1'b0, 12'h008, 32'h0);
    check(rd, 32'h0);
    check({31'h0, er}, 32'h1);
    // Second reset restores strap multiplier and divider of 2
    req_n <= 1'b0;
    while (core_reset_n !== 1'b0) @(posedge core_clk);
    repeat (20) @(posedge core_clk);
    apb(1'b0, pcr_pkg::PMC_OFFSET, 32'h0);
    check(rd & 32'h37F, {25'h0, pcr_pkg::STRAP_MULT_3});
    release_core();
    end_of_test();
  end
endmodule // pcr_clock_reset_tb
